// *** qdc_pkg.sv ***
// constants and types shared by the quadrature decoder/counter
package qdc_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int CNT_WIDTH_DEFAULT = 16; // 12 or 16
  localparam int FILT_HIST_BITS = 4;    // history held per channel
  localparam int FILT_STABLE = 3;       // equal samples needed
  localparam int BYTE_BITS = 8;

  // ****************************************************************
  // byte pick encoding and reset values
  // ****************************************************************
  localparam logic SEL_HIGH_BYTE = 1'b0;
  localparam logic SEL_LOW_BYTE = 1'b1;
  localparam logic [3:0] FILT_HIST_RST = 4'h0;
  localparam logic FILT_OUT_RST = 1'b0;
  localparam logic DIR_UP = 1'b1;
  localparam logic DIR_DOWN = 1'b0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ****************************************************************
  // inhibit states
  // ****************************************************************
  typedef enum logic [1:0] {
    INH_FREE,
    INH_HOLD,
    INH_LOW_SEEN
  } qdc_inh_state_t;

endpackage

// *** qdc_filt_if.sv ***
// filtered channel levels passed from filter to decoder
`timescale 1ns/1ns
interface qdc_filt_if;
  logic chanA;
  logic chanB;
  modport filt (output chanA, output chanB);
  modport dec (input chanA, input chanB);
endinterface

// *** qdc_filter.sv ***
// per-channel digital noise filter for both quadrature phases
`timescale 1ns/1ns
module qdc_filter (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic quad_phase_a_in,
  input wire logic quad_phase_b_in,
  qdc_filt_if.filt filtOut
);
  import qdc_pkg::*;

  logic [3:0] histA_q;
  logic [3:0] histA_d;
  logic [3:0] histB_q;
  logic [3:0] histB_d;
  logic outA_q;
  logic outA_d;
  logic outB_q;
  logic outB_d;

  // ****************************************************************
  // history shift and stable-level check
  // ****************************************************************
  // shift in on every rising edge, output moves only on three equal
  always_comb begin
    histA_d = {histA_q[2:0], quad_phase_a_in};
    histB_d = {histB_q[2:0], quad_phase_b_in};
    outA_d = outA_q;
    outB_d = outB_q;
    if (histA_q[2:0] == 3'b111) outA_d = 1'b1;
    if (histA_q[2:0] == 3'b000) outA_d = 1'b0;
    if (histB_q[2:0] == 3'b111) outB_d = 1'b1;
    if (histB_q[2:0] == 3'b000) outB_d = 1'b0;
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      histA_q <= FILT_HIST_RST;
      histB_q <= FILT_HIST_RST;
      outA_q <= FILT_OUT_RST;
      outB_q <= FILT_OUT_RST;
    end else begin
      histA_q <= histA_d;
      histB_q <= histB_d;
      outA_q <= outA_d;
      outB_q <= outB_d;
    end
  end

  assign filtOut.chanA = outA_q;
  assign filtOut.chanB = outB_q;
endmodule

// *** qdc_decoder.sv ***
// 4x quadrature decoder: step and direction from filtered phases
`timescale 1ns/1ns
module qdc_decoder (
  input wire logic core_clk,
  input wire logic sys_rst,
  qdc_filt_if.dec filtIn,
  output logic step,
  output logic dirUp
);
  import qdc_pkg::*;

  logic [1:0] prev_q;
  logic [1:0] prev_d;
  logic [1:0] curPos;
  logic [1:0] delta;

  // ****************************************************************
  // state compare
  // ****************************************************************
  // phase order 00,10,11,01 counts up (a leads b)
  always_comb begin
    // gray {b,a} to binary so the up order reads 0,1,2,3
    curPos = {filtIn.chanB, filtIn.chanA ^ filtIn.chanB};
    delta = curPos - prev_q;
    prev_d = curPos;
    step = (delta != 2'd0);
    // two-step jumps are counted up, no error raised
    dirUp = (delta == 2'd3) ? DIR_DOWN : DIR_UP;
  end

  // previous state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_q <= 2'd0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

// *** qdc_counter_top.sv ***
// quadrature decoder/counter with latched byte-wide read port
// Behaviour
// - reset clears counter, latch and inhibit
// - data driven only while output enable low; here dataOe is registered and follows outEnN one rising edge late
// - falling edge samples enable and byte pick
// - byte pick 0 high byte, 1 low
// - counter and latch 12 or 16 bits
// - 12-bit mode top four high bits zero
// - uninhibited latch follows counter each rising edge
// - step pulse on each valid transition
// - direction high up, valid before pulses; here it changes on the same rising edge that raises the pulse
// - wrap pulse on overflow or underflow
// - pulses rise after rising, fall after falling
// - four-bit sample history per channel
// - filter output needs three equal samples
// - spikes and sub-three-period pulses rejected
// - count every edge, four per cycle
// - count from previous and current state
// - a leads b up, b leads a down
// - illegal transitions not flagged, may miscount
`timescale 1ns/1ns
module qdc_counter_top #(
  parameter int CNT_WIDTH = qdc_pkg::CNT_WIDTH_DEFAULT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic quad_phase_a_in,
  input wire logic quad_phase_b_in,
  input wire logic outEnN,
  input wire logic byteSel,
  output logic [qdc_pkg::BYTE_BITS-1:0] dataOut,
  output logic dataOe,
  output logic dirUpOut,
  output logic decoder_step_pulse,
  output logic wrap_pulse
);
  import qdc_pkg::*;

  localparam logic [CNT_WIDTH-1:0] CNT_MAX = {CNT_WIDTH{1'b1}};
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = '0;

  qdc_filt_if filtBus ();
  logic decStep;
  logic decDirUp;

  logic [CNT_WIDTH-1:0] cnt_q;
  logic [CNT_WIDTH-1:0] cnt_d;
  logic [CNT_WIDTH-1:0] latch_q;
  logic [CNT_WIDTH-1:0] latch_d;
  logic [15:0] latchWide;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic oe_q;
  logic oe_d;
  logic dir_q;
  logic dir_d;
  logic stepTgl_q;
  logic stepTgl_d;
  logic wrapTgl_q;
  logic wrapTgl_d;
  logic stepAck_q;
  logic stepAck_d;
  logic wrapAck_q;
  logic wrapAck_d;
  logic wrapEvt;
  qdc_inh_state_t inh_q;
  qdc_inh_state_t inh_d;
  logic inhibit;

  // ****************************************************************
  // input filter and decoder
  // ****************************************************************
  qdc_filter uFilter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .quad_phase_a_in(quad_phase_a_in),
    .quad_phase_b_in(quad_phase_b_in),
    .filtOut(filtBus)
  );

  qdc_decoder uDecoder (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .filtIn(filtBus),
    .step(decStep),
    .dirUp(decDirUp)
  );

  // ****************************************************************
  // inhibit logic, falling-edge domain of the same clock
  // ****************************************************************
  // hold the latch from first enable low until low byte read ends
  always_comb begin
    inh_d = inh_q;
    case (inh_q)
      INH_FREE: begin
        if (!outEnN && byteSel == SEL_LOW_BYTE) begin
          inh_d = INH_LOW_SEEN;
        end else if (!outEnN) begin
          inh_d = INH_HOLD;
        end
      end
      INH_HOLD: begin
        if (!outEnN && byteSel == SEL_LOW_BYTE) begin
          inh_d = INH_LOW_SEEN;
        end
      end
      INH_LOW_SEEN: begin
        if (outEnN) inh_d = INH_FREE;
      end
      default: inh_d = INH_FREE;
    endcase
  end

  // pulse return acknowledges also live on the falling edge
  always_comb begin
    stepAck_d = stepTgl_q;
    wrapAck_d = wrapTgl_q;
  end

  always_ff @(negedge core_clk) begin
    if (sys_rst) begin
      inh_q <= INH_FREE;
      stepAck_q <= 1'b0;
      wrapAck_q <= 1'b0;
    end else begin
      inh_q <= inh_d;
      stepAck_q <= stepAck_d;
      wrapAck_q <= wrapAck_d;
    end
  end

  assign inhibit = (inh_q != INH_FREE);

  // ****************************************************************
  // position counter, latch and cascade events
  // ****************************************************************
  always_comb begin
    cnt_d = cnt_q;
    wrapEvt = 1'b0;
    dir_d = dir_q;
    if (decStep) begin
      dir_d = decDirUp;
      if (decDirUp == DIR_UP) begin
        cnt_d = cnt_q + 1'b1;
        wrapEvt = (cnt_q == CNT_MAX);
      end else begin
        cnt_d = cnt_q - 1'b1;
        wrapEvt = (cnt_q == CNT_ZERO);
      end
    end
    // the latch takes the new count unless a read holds it
    latch_d = inhibit ? latch_q : cnt_d;
    stepTgl_d = stepTgl_q ^ decStep;
    wrapTgl_d = wrapTgl_q ^ wrapEvt;
  end

  // ****************************************************************
  // byte port
  // ****************************************************************
  // unused upper bits of a 12-bit count read as zero
  always_comb begin
    latchWide = 16'h0000;
    latchWide[CNT_WIDTH-1:0] = latch_d;
    if (byteSel == SEL_HIGH_BYTE) begin
      data_d = latchWide[15:8];
    end else begin
      data_d = latchWide[7:0];
    end
    oe_d = !outEnN;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= CNT_ZERO;
      latch_q <= CNT_ZERO;
      data_q <= DATA_RST;
      oe_q <= 1'b0;
      dir_q <= DIR_UP;
      stepTgl_q <= 1'b0;
      wrapTgl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      latch_q <= latch_d;
      data_q <= data_d;
      oe_q <= oe_d;
      dir_q <= dir_d;
      stepTgl_q <= stepTgl_d;
      wrapTgl_q <= wrapTgl_d;
    end
  end

  // outputs; pulses are the difference of two edge toggles
  assign dataOut = data_q;
  assign dataOe = oe_q;
  assign dirUpOut = dir_q;
  assign decoder_step_pulse = stepTgl_q ^ stepAck_q;
  assign wrap_pulse = wrapTgl_q ^ wrapAck_q;
endmodule

// *** qdc_counter_sva.sv ***
// pin-level assertions for the quadrature decoder/counter
`timescale 1ns/1ns
module qdc_counter_sva #(
  parameter int CNT_WIDTH = qdc_pkg::CNT_WIDTH_DEFAULT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic quad_phase_a_in,
  input wire logic quad_phase_b_in,
  input wire logic outEnN,
  input wire logic byteSel,
  input wire logic [qdc_pkg::BYTE_BITS-1:0] dataOut,
  input wire logic dataOe,
  input wire logic dirUpOut,
  input wire logic decoder_step_pulse,
  input wire logic wrap_pulse
);
  import qdc_pkg::*;
  // ******
  // checks, rising edge unless named
  // ******
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  rst_clear_a: assert property ($past(sys_rst) |-> dataOut == 8'h00)
    else $error("data not cleared");
  oe_off_a: assert property (outEnN [*2] |-> !dataOe)
    else $error("pins driven while disabled");
  latch_hold_a: assert property (
    (!outEnN && byteSel == SEL_HIGH_BYTE) [*3] |-> $stable(dataOut))
    else $error("latch moved while held");
  high_zero_a: assert property (
    CNT_WIDTH == 12 && dataOe && $past(byteSel) == SEL_HIGH_BYTE
    |-> dataOut[7:4] == 4'h0)
    else $error("unused high bits set");
  pulse_low_a: assert property (!decoder_step_pulse && !wrap_pulse)
    else $error("pulse still high at rising edge");
  quiet_step_a: assert property (@(negedge core_clk)
    ($stable(quad_phase_a_in) && $stable(quad_phase_b_in)) [*8]
    |-> !decoder_step_pulse)
    else $error("step without input change");
  dir_change_a: assert property (@(negedge core_clk)
    $changed(dirUpOut) |-> decoder_step_pulse)
    else $error("direction moved without step");
  wrap_step_a: assert property (@(negedge core_clk)
    wrap_pulse |-> decoder_step_pulse)
    else $error("wrap without step");
  // main scenarios reached
  step_c: cover property (@(negedge core_clk) decoder_step_pulse);
  wrap_c: cover property (@(negedge core_clk) wrap_pulse);
  read_c: cover property (!outEnN [*3] ##1 outEnN);
endmodule
bind qdc_counter_top qdc_counter_sva #(.CNT_WIDTH(CNT_WIDTH)) u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst),
  .quad_phase_a_in(quad_phase_a_in), .quad_phase_b_in(quad_phase_b_in),
  .outEnN(outEnN), .byteSel(byteSel), .dataOut(dataOut), .dataOe(dataOe),
  .dirUpOut(dirUpOut), .decoder_step_pulse(decoder_step_pulse),
  .wrap_pulse(wrap_pulse)
);

// *** qdc_host_model.sv ***
// host model reading the position latch byte by byte
`timescale 1ns/1ns
module qdc_host_model (
  input wire logic core_clk,
  input wire logic [qdc_pkg::BYTE_BITS-1:0] dataOut,
  input wire logic dataOe,
  output logic outEnN,
  output logic byteSel
);
  import qdc_pkg::*;
  // bus idle, enable released
  initial begin
    outEnN = 1'b1;
    byteSel = SEL_HIGH_BYTE;
  end
  // undriven pins read back inverted, never a stale match
  function automatic logic [7:0] pins();
    return dataOe ? dataOut : ~dataOut;
  endfunction
  // enable with high byte picked, take the high byte first
  task automatic readHi(output logic [7:0] b);
    @(posedge core_clk);
    outEnN <= 1'b0;
    byteSel <= SEL_HIGH_BYTE;
    repeat (2) @(negedge core_clk);
    b = pins();
  endtask
  // pick low byte second, take it, then release enable
  task automatic readLo(output logic [7:0] b);
    @(posedge core_clk);
    byteSel <= SEL_LOW_BYTE;
    @(posedge core_clk);
    @(negedge core_clk);
    b = pins();
    @(posedge core_clk);
    outEnN <= 1'b1;
    byteSel <= SEL_HIGH_BYTE;
  endtask
endmodule

// *** quadrature_decoder_counter_tb_top.sv ***
// self-checking bench for the quadrature decoder/counter
`timescale 1ns/1ns
module quadrature_decoder_counter_tb_top;
  import qdc_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic quad_phase_a_in = 1'b0;
  logic quad_phase_b_in = 1'b0;
  logic outEnN;
  logic byteSel;
  logic [7:0] dataOut;
  logic dataOe;
  logic dirUpOut;
  logic decoder_step_pulse;
  logic wrap_pulse;
  logic [7:0] dataOutNarrow;
  logic dataOeNarrow;
  logic [1:0] ph = 2'h0;
  logic [15:0] v;
  int fails = 0;
  int compares = 0;
  int steps = 0;
  int wraps = 0;
  // clock and pulse counters
  always #5 core_clk = ~core_clk;
  always @(posedge decoder_step_pulse) steps++;
  always @(posedge wrap_pulse) wraps++;
  qdc_counter_top u_qdc_counter_top (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .quad_phase_a_in(quad_phase_a_in), .quad_phase_b_in(quad_phase_b_in),
    .outEnN(outEnN), .byteSel(byteSel), .dataOut(dataOut), .dataOe(dataOe),
    .dirUpOut(dirUpOut), .decoder_step_pulse(decoder_step_pulse),
    .wrap_pulse(wrap_pulse)
  );
  // 12-bit variant on the same inputs, read alongside the full one
  qdc_counter_top #(.CNT_WIDTH(12)) u_qdc_counter_top_narrow (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .quad_phase_a_in(quad_phase_a_in), .quad_phase_b_in(quad_phase_b_in),
    .outEnN(outEnN), .byteSel(byteSel), .dataOut(dataOutNarrow),
    .dataOe(dataOeNarrow), .dirUpOut(), .decoder_step_pulse(),
    .wrap_pulse()
  );
  qdc_host_model u_qdc_host_model (
    .core_clk(core_clk), .dataOut(dataOut), .dataOe(dataOe),
    .outEnN(outEnN), .byteSel(byteSel)
  );
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // full position read, high byte then low
  task automatic rd(output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    u_qdc_host_model.readHi(h);
    u_qdc_host_model.readLo(l);
    r = {h, l};
  endtask
  // quadrature steps, each level held five clocks
  task automatic move(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      ph = up ? ph + 2'h1 : ph - 2'h1;
      @(posedge core_clk);
      quad_phase_a_in <= ph[1] ^ ph[0];
      quad_phase_b_in <= ph[1];
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask
  // phase a pulse lasting w samples
  task automatic pulse(input int w);
    @(posedge core_clk);
    quad_phase_a_in <= 1'b1;
    repeat (w) @(posedge core_clk);
    quad_phase_a_in <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  // up, down through zero, up through the top
  task automatic t_updown();
    int s0;
    logic [7:0] h;
    logic [7:0] l;
    s0 = steps;
    move(6, 1'b1);
    rd(v);
    check(v, 16'h0006);
    check(16'(dirUpOut), 16'h0001);
    check(16'(steps - s0), 16'h0006);
    move(9, 1'b0);
    u_qdc_host_model.readHi(h);
    check({7'h00, dataOeNarrow, dataOutNarrow}, 16'h010F);
    u_qdc_host_model.readLo(l);
    check({h, l}, 16'hFFFD);
    check(16'(dirUpOut), 16'h0000);
    check(16'(wraps), 16'h0001);
    move(3, 1'b1);
    rd(v);
    check(v, 16'h0000);
    check(16'(wraps), 16'h0002);
  endtask
  // short pulses dropped, three samples pass
  task automatic t_filter();
    int s0;
    s0 = steps;
    pulse(1);
    pulse(2);
    check(16'(steps - s0), 16'h0000);
    pulse(3);
    check(16'(steps - s0), 16'h0002);
    rd(v);
    check(v, 16'h0000);
  endtask
  // counting during a read leaves the held value
  task automatic t_hold();
    logic [7:0] h;
    logic [7:0] l;
    u_qdc_host_model.readHi(h);
    move(4, 1'b1);
    u_qdc_host_model.readLo(l);
    check({h, l}, 16'h0000);
    rd(v);
    check(v, 16'h0004);
  endtask
  // reset in mid-run clears a nonzero count
  task automatic t_reset();
    move(4, 1'b1);
    rd(v);
    check(v, 16'h0008);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(v);
    check(v, 16'h0000);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(v);
    check(v, 16'h0000);
    t_updown();
    t_filter();
    t_hold();
    t_reset();
    close_out();
  end
  // watchdog
  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule
